// ---- logic/psl_ctrl.sv ----
// coding layer control: config registers over axi4-lite, lock tracking, interleave control
`timescale 1ns/1ns
`default_nettype none
`include "psl_consts.svh"
module psl_ctrl
  import psl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  // axi4-lite slave
  input wire logic [15:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [15:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // receive symbol stream from the decoder, same clock
  input wire logic rx_sym_valid_i,
  input wire logic rx_sym_idle_i,
  input wire logic rx_sym_error_i,
  input wire logic rx_in_gap_i,
  input wire logic rx_interleave_seen_i,
  // progress of the equalizer training engine
  input wire logic training_stage_one_done_i,
  // control and status towards the rest of the transceiver
  output logic training_start_en_o,
  output logic force_training_stage_one_complete_o,
  output logic stage_one_done_o,
  output logic scrambler_locked_o,
  output logic remote_rcvr_ok_o,
  output logic interleave_detect_en_o,
  output logic interleave_detected_o,
  output logic tx_interleave_o
);

  // reset synchroniser: assert at once, release two edges later
  logic rst_q1;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // configuration registers
  psl_reg_t ctrl1;
  psl_reg_t ctrl2;
  psl_reg_t txi;
  psl_reg_t status;

  // field views
  logic link_start;
  logic force_stage1;
  logic dis_gap_check;
  logic [`PSL_CNT_W-1:0] lock_thresh;
  logic [`PSL_CNT_W-1:0] unlock_thresh;
  logic [`PSL_CNT_W-1:0] rem_err_thresh;
  logic force_txi;
  logic cond_txi;
  logic det_en;

  assign link_start = ctrl1[`PSL_C1_LINK_START];
  assign force_stage1 = ctrl1[`PSL_C1_FORCE_STAGE1];
  assign dis_gap_check = ctrl1[`PSL_C1_DIS_IPG_CHECK];
  assign lock_thresh = ctrl1[`PSL_C1_LOCK_CNT_HI:0];
  assign unlock_thresh = {1'b0, ctrl2[`PSL_C2_UNLOCK_CNT_HI:`PSL_C2_UNLOCK_CNT_LO]};
  assign rem_err_thresh = {{(`PSL_CNT_W - `PSL_C2_REM_ERR_HI - 1){1'b0}}, ctrl2[`PSL_C2_REM_ERR_HI:0]};
  assign force_txi = txi[`PSL_TXI_FORCE];
  assign cond_txi = txi[`PSL_TXI_COND];
  assign det_en = txi[`PSL_TXI_DET_EN];

  // ---------------- axi4-lite write path ----------------
  logic aw_held;
  logic [15:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ctrl1;
  logic wr_ctrl2;
  logic wr_txi;
  logic wr_status;
  logic wr_hit;
  logic [11:0] wr_idx;

  // one slot per channel; address and data may arrive in either order
  assign s_axi_awready_o = ~aw_held;
  assign s_axi_wready_o = ~w_held;
  // the write commits once both halves are held and no response is pending
  assign do_write = aw_held & w_held & ~s_axi_bvalid_o;

  // decode; the two top address bits must be zero for a hit
  assign wr_idx = aw_addr[13:2];
  assign wr_ctrl1 = (aw_addr[15:14] == 2'b00) && (wr_idx == `PSL_IDX_CTRL1);
  assign wr_ctrl2 = (aw_addr[15:14] == 2'b00) && (wr_idx == `PSL_IDX_CTRL2);
  assign wr_txi = (aw_addr[15:14] == 2'b00) && (wr_idx == `PSL_IDX_TXI);
  assign wr_status = (aw_addr[15:14] == 2'b00) && (wr_idx == `PSL_IDX_STATUS);
  assign wr_hit = wr_ctrl1 | wr_ctrl2 | wr_txi | wr_status;

  // write address slot
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid_i && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr_i;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // write data slot
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid_i && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata_i;
      w_strb <= s_axi_wstrb_i;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `PSL_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o <= wr_hit ? `PSL_RESP_OKAY : `PSL_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // byte-lane merge; lanes 2 and 3 have no storage and are dropped
  function automatic psl_reg_t psl_merge(input psl_reg_t old_val, input logic [31:0] data,
                                         input logic [3:0] strb, input psl_reg_t mask);
    psl_reg_t merged;
    merged = old_val;
    if (strb[0]) begin
      merged[7:0] = data[7:0];
    end
    if (strb[1]) begin
      merged[15:8] = data[15:8];
    end
    psl_merge = merged & mask;
  endfunction

  // control one: link start, forced stage one, gap check and lock count
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl1 <= `PSL_CTRL1_RST;
    end else if (do_write && wr_ctrl1) begin
      ctrl1 <= psl_merge(ctrl1, w_data, w_strb, `PSL_CTRL1_MASK);
    end
  end

  // control two: unlock count and remote error count
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl2 <= `PSL_CTRL2_RST;
    end else if (do_write && wr_ctrl2) begin
      ctrl2 <= psl_merge(ctrl2, w_data, w_strb, `PSL_CTRL2_MASK);
    end
  end

  // interleave configuration
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      txi <= `PSL_TXI_RST;
    end else if (do_write && wr_txi) begin
      txi <= psl_merge(txi, w_data, w_strb, `PSL_TXI_MASK);
    end
  end

  // ---------------- axi4-lite read path ----------------
  logic rd_take;
  logic [11:0] rd_idx;
  logic rd_top_ok;
  psl_reg_t rd_val;
  logic rd_hit;

  // a new read is accepted only when no read data is waiting
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign rd_take = s_axi_arvalid_i & ~s_axi_rvalid_o;
  assign rd_idx = s_axi_araddr_i[13:2];
  assign rd_top_ok = (s_axi_araddr_i[15:14] == 2'b00);

  // read mux; reserved bits come back as zero
  always_comb begin
    rd_val = '0;
    rd_hit = rd_top_ok;
    case (rd_idx)
      `PSL_IDX_CTRL1: rd_val = ctrl1;
      `PSL_IDX_CTRL2: rd_val = ctrl2;
      `PSL_IDX_TXI: rd_val = txi;
      `PSL_IDX_STATUS: rd_val = status;
      default: rd_hit = 1'b0;
    endcase
    if (!rd_top_ok) begin
      rd_val = '0;
    end
  end

  // read data register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= `PSL_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o <= {16'h0000, rd_val};
      s_axi_rresp_o <= rd_hit ? `PSL_RESP_OKAY : `PSL_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------- descrambler lock tracking ----------------
  psl_lock_state_t state;
  psl_lock_state_t next_state;
  logic lock_hit;
  logic unlock_hit;
  logic err_hit;
  logic gap_sym;
  logic rem_fail;

  // only non-idle symbols inside a gap betray a lost lock; data symbols are expected
  assign gap_sym = rx_sym_valid_i & rx_in_gap_i & ~dis_gap_check;

  // consecutive idles while hunting
  psl_run_cnt u_lock_cnt (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(state != PSL_HUNT),
    .sym_i(rx_sym_valid_i),
    .hit_i(rx_sym_idle_i),
    .thresh_i(lock_thresh),
    .reached_o(lock_hit)
  );

  // consecutive non-idles in gaps while locked
  psl_run_cnt u_unlock_cnt (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(state != PSL_LOCKED),
    .sym_i(gap_sym),
    .hit_i(~rx_sym_idle_i),
    .thresh_i(unlock_thresh),
    .reached_o(unlock_hit)
  );

  // consecutive error symbols while locked
  psl_run_cnt u_err_cnt (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .clear_i(state != PSL_LOCKED),
    .sym_i(rx_sym_valid_i),
    .hit_i(rx_sym_error_i),
    .thresh_i(rem_err_thresh),
    .reached_o(err_hit)
  );

  // lock state: clearing the start enable drops the link at once
  always_comb begin
    next_state = state;
    case (state)
      PSL_DOWN: begin
        if (link_start) begin
          next_state = PSL_HUNT;
        end
      end
      PSL_HUNT: begin
        if (!link_start) begin
          next_state = PSL_DOWN;
        end else if (lock_hit) begin
          next_state = PSL_LOCKED;
        end
      end
      PSL_LOCKED: begin
        if (!link_start) begin
          next_state = PSL_DOWN;
        end else if (unlock_hit) begin
          next_state = PSL_HUNT;
        end
      end
      default: next_state = PSL_DOWN;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= PSL_DOWN;
    end else begin
      state <= next_state;
    end
  end

  // remote status failure holds until the lock is lost or a good symbol arrives
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rem_fail <= 1'b0;
    end else if (state != PSL_LOCKED) begin
      rem_fail <= 1'b0;
    end else if (err_hit) begin
      rem_fail <= 1'b1;
    end else if (rx_sym_valid_i && !rx_sym_error_i) begin
      rem_fail <= 1'b0;
    end
  end

  // ---------------- interleave detection ----------------
  logic detected;

  // latched once seen; disabling detection or dropping the link forgets it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      detected <= 1'b0;
    end else if (!det_en || state == PSL_DOWN) begin
      detected <= 1'b0;
    end else if (rx_interleave_seen_i) begin
      detected <= 1'b1;
    end
  end

  // ---------------- registered outputs ----------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      training_start_en_o <= 1'b0;
      force_training_stage_one_complete_o <= 1'b0;
      stage_one_done_o <= 1'b0;
      scrambler_locked_o <= 1'b0;
      remote_rcvr_ok_o <= 1'b0;
      interleave_detect_en_o <= 1'b0;
      interleave_detected_o <= 1'b0;
      tx_interleave_o <= 1'b0;
    end else begin
      training_start_en_o <= link_start;
      force_training_stage_one_complete_o <= force_stage1;
      stage_one_done_o <= force_stage1 | training_stage_one_done_i;
      scrambler_locked_o <= (next_state == PSL_LOCKED);
      remote_rcvr_ok_o <= (next_state == PSL_LOCKED) & ~rem_fail & ~err_hit;
      interleave_detect_en_o <= det_en;
      interleave_detected_o <= detected;
      tx_interleave_o <= force_txi | (cond_txi & detected);
    end
  end

  // status word for software, taken from the registered outputs
  always_comb begin
    status = '0;
    status[`PSL_ST_LINK_START] = training_start_en_o;
    status[`PSL_ST_STAGE1] = stage_one_done_o;
    status[`PSL_ST_LOCKED] = scrambler_locked_o;
    status[`PSL_ST_REM_OK] = remote_rcvr_ok_o;
    status[`PSL_ST_DETECTED] = interleave_detected_o;
    status[`PSL_ST_TX_INTERLEAVE] = tx_interleave_o;
  end

endmodule
`default_nettype wire

// ---- logic/psl_consts.svh ----
// register map, field positions, reset values and widths of the coding layer control block
// Functional notes
// - training and link-up may start only while the training start enable bit is set, which resets to one.
// - the force stage-one-complete bit makes stage one of slave equalizer training count as done; it resets to zero.
// - the gap lock check disable bit skips the descrambler lock check during inter-packet gaps; clear means check.
// - lock is declared after the number of idle symbols in the nine-bit lock count field, reset 1111000b.
// - unlock is declared after the number of non-idle symbols in the eight-bit unlock count field, reset 1010b.
// - remote receiver status goes low once error symbols reach the five-bit error count field, reset 101b.
// - the force transmit interleave bit turns transmit interleaving on unconditionally; it resets to zero.
// - the conditional transmit interleave bit interleaves transmit only if receive interleave was detected.
// - receive interleave detection runs only while its enable bit is one, which is its reset value.
`ifndef PSL_CONSTS_SVH
`define PSL_CONSTS_SVH

// register indices; byte address is four times the index
`define PSL_IDX_CTRL1 12'h485
`define PSL_IDX_CTRL2 12'h486
`define PSL_IDX_TXI 12'h489
`define PSL_IDX_STATUS 12'h48f

// reset values and writable bit masks
`define PSL_CTRL1_RST 16'h1078
`define PSL_CTRL2_RST 16'h0a05
`define PSL_TXI_RST 16'h0001
`define PSL_CTRL1_MASK 16'h71ff
`define PSL_CTRL2_MASK 16'hff1f
`define PSL_TXI_MASK 16'h0007

// field positions
`define PSL_C1_FORCE_STAGE1 14
`define PSL_C1_DIS_IPG_CHECK 13
`define PSL_C1_LINK_START 12
`define PSL_C1_LOCK_CNT_HI 8
`define PSL_C2_UNLOCK_CNT_HI 15
`define PSL_C2_UNLOCK_CNT_LO 8
`define PSL_C2_REM_ERR_HI 4
`define PSL_TXI_FORCE 2
`define PSL_TXI_COND 1
`define PSL_TXI_DET_EN 0

// status register bits
`define PSL_ST_LINK_START 0
`define PSL_ST_STAGE1 1
`define PSL_ST_LOCKED 2
`define PSL_ST_REM_OK 3
`define PSL_ST_DETECTED 4
`define PSL_ST_TX_INTERLEAVE 5

// counter width and bus constants
`define PSL_CNT_W 9
`define PSL_RESP_OKAY 2'b00
`define PSL_RESP_SLVERR 2'b10

`endif

// ---- logic/psl_pkg.sv ----
// types shared by the coding layer control block
package psl_pkg;

  // descrambler lock states, gray coded along down -> hunt -> locked
  typedef enum logic [1:0] {
    PSL_DOWN = 2'b00,
    PSL_HUNT = 2'b01,
    PSL_LOCKED = 2'b11
  } psl_lock_state_t;

  typedef logic [15:0] psl_reg_t;

endpackage

// ---- logic/psl_run_cnt.sv ----
// run-length counter that flags when a symbol run reaches a programmed length
`timescale 1ns/1ns
`default_nettype none
`include "psl_consts.svh"
module psl_run_cnt
  import psl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic sym_i,
  input wire logic hit_i,
  input wire logic [`PSL_CNT_W-1:0] thresh_i,
  output logic reached_o
);

  logic [`PSL_CNT_W-1:0] cnt;
  logic [`PSL_CNT_W:0] next_cnt;

  // length including the current symbol; a zero threshold fires on the first hit
  assign next_cnt = {1'b0, cnt} + {{`PSL_CNT_W{1'b0}}, 1'b1};
  assign reached_o = sym_i & hit_i & (next_cnt >= {1'b0, thresh_i});

  // run counter; a broken run or a firing starts over from zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= '0;
    end else if (clear_i || reached_o) begin
      cnt <= '0;
    end else if (sym_i) begin
      if (hit_i) begin
        cnt <= next_cnt[`PSL_CNT_W-1:0];
      end else begin
        cnt <= '0;
      end
    end
  end

endmodule
`default_nettype wire

// ---- tb/psl_link_partner.sv ----
// behavioural link partner that feeds received symbols into the control block
`timescale 1ns/1ns
`default_nettype none
module psl_link_partner (
  input wire logic clk_i,
  output logic sym_valid_o,
  output logic sym_idle_o,
  output logic sym_error_o,
  output logic in_gap_o,
  output logic interleave_seen_o
);
  logic slow;
  // start quiet: no symbol, no interleave seen
  initial begin
    slow = 1'b0;
    sym_valid_o = 1'b0;
    sym_idle_o = 1'b0;
    sym_error_o = 1'b0;
    in_gap_o = 1'b0;
    interleave_seen_o = 1'b0;
  end
  // n symbols of one kind; dead cycles carry inverted qualifiers so stale values never pass for a symbol
  task automatic send(input int n, input logic idle, input logic err, input logic gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      if (slow) begin
        sym_valid_o <= 1'b0;
        sym_idle_o <= ~idle;
        sym_error_o <= ~err;
        in_gap_o <= ~gap;
        @(posedge clk_i);
      end
      sym_valid_o <= 1'b1;
      sym_idle_o <= idle;
      sym_error_o <= err;
      in_gap_o <= gap;
    end
    @(posedge clk_i);
    sym_valid_o <= 1'b0;
    sym_idle_o <= ~idle;
    sym_error_o <= ~err;
    in_gap_o <= ~gap;
  endtask
  // one-cycle report that the receive path saw interleaving
  task automatic show_interleave();
    @(posedge clk_i);
    interleave_seen_o <= 1'b1;
    @(posedge clk_i);
    interleave_seen_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- tb/psl_ctrl_sva.sv ----
// concurrent checks on the ports of the coding layer control block
`timescale 1ns/1ns
`default_nettype none
module psl_ctrl_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic rx_sym_valid_i,
  input wire logic rx_sym_idle_i,
  input wire logic rx_sym_error_i,
  input wire logic rx_in_gap_i,
  input wire logic rx_interleave_seen_i,
  input wire logic training_start_en_o,
  input wire logic force_training_stage_one_complete_o,
  input wire logic stage_one_done_o,
  input wire logic scrambler_locked_o,
  input wire logic remote_rcvr_ok_o,
  input wire logic interleave_detect_en_o,
  input wire logic interleave_detected_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // address and data land together on an idle slave, answer two edges on
  sequence wr_both;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o && !s_axi_bvalid_o;
  endsequence
  sequence wr_answer;
    ##2 s_axi_bvalid_o;
  endsequence
  a_write_answer: assert property (wr_both |-> wr_answer)
    else $error("write response not on time");
  a_bvalid_drop: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data not on time");
  a_read_single: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while data pending");
  a_lock_on_idle: assert property ($rose(scrambler_locked_o) |-> $past(rx_sym_valid_i) && $past(rx_sym_idle_i))
    else $error("lock without an idle symbol");
  // link disable is the only other way out of lock
  a_unlock_in_gap: assert property ($fell(scrambler_locked_o) |-> !training_start_en_o ||
    ($past(rx_sym_valid_i) && !$past(rx_sym_idle_i) && $past(rx_in_gap_i)))
    else $error("unlock without a non-idle gap symbol");
  a_remote_recover: assert property (scrambler_locked_o && !remote_rcvr_ok_o && rx_sym_valid_i &&
    !rx_sym_error_i |=> ##1 (remote_rcvr_ok_o || !scrambler_locked_o))
    else $error("remote status not restored");
  a_remote_locked: assert property ($rose(remote_rcvr_ok_o) |-> scrambler_locked_o)
    else $error("remote status good while unlocked");
  a_detect_latch: assert property (rx_interleave_seen_i && interleave_detect_en_o &&
    training_start_en_o |=> ##1 interleave_detected_o)
    else $error("interleave not latched");
  a_stage_force: assert property (force_training_stage_one_complete_o |-> stage_one_done_o)
    else $error("forced stage one not done");
endmodule
`default_nettype wire

// ---- tb/psl_ctrl_test.sv ----
// self-checking bench for the coding layer control block
`timescale 1ns/1ns
`default_nettype none
`include "psl_consts.svh"
module psl_ctrl_test;
  logic clk_i, rstn_i, awvalid, wvalid, bready, arvalid, rready, stage_done;
  logic awready, wready, bvalid, arready, rvalid, sv, si, se, sg, ss;
  logic t_en, f1, s1, lk, rok, den, det, txi;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  int err_count, n_tests;

  psl_ctrl DUT (.clk_i(clk_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_sym_valid_i(sv),
    .rx_sym_idle_i(si), .rx_sym_error_i(se), .rx_in_gap_i(sg), .rx_interleave_seen_i(ss),
    .training_stage_one_done_i(stage_done), .training_start_en_o(t_en),
    .force_training_stage_one_complete_o(f1), .stage_one_done_o(s1), .scrambler_locked_o(lk),
    .remote_rcvr_ok_o(rok), .interleave_detect_en_o(den), .interleave_detected_o(det), .tx_interleave_o(txi));
  psl_link_partner link (.clk_i(clk_i), .sym_valid_o(sv), .sym_idle_o(si), .sym_error_o(se),
    .in_gap_o(sg), .interleave_seen_o(ss));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one write; valids drop at the edge that takes them, bready stays up until the answer
  task automatic wr(input logic [11:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge clk_i);
    b = 1'b0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the wait ends once bvalid is seen at a falling edge
    while (!b) begin
      @(negedge clk_i);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk_i);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("write response", er, r);
  endtask
  // one read, judged against the expected word and response
  task automatic rd(input logic [11:0] idx, input logic [15:0] exp, input logic [1:0] er);
    logic a, v;
    logic [31:0] got;
    logic [1:0] r;
    @(posedge clk_i);
    v = 1'b0;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!v) begin
      @(negedge clk_i);
      a = arvalid && arready;
      v = rvalid;
      got = rdata;
      r = rresp;
      @(posedge clk_i);
      if (a) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    chk("read data", {16'h0000, exp}, got);
    chk("read response", er, r);
  endtask

  task automatic t_reset_values();
    rd(`PSL_IDX_CTRL1, `PSL_CTRL1_RST, `PSL_RESP_OKAY);
    rd(`PSL_IDX_CTRL2, `PSL_CTRL2_RST, `PSL_RESP_OKAY);
    rd(`PSL_IDX_TXI, `PSL_TXI_RST, `PSL_RESP_OKAY);
    rd(12'h400, 16'h0000, `PSL_RESP_SLVERR);
    wr(12'h400, 16'hffff, `PSL_RESP_SLVERR);
    @(negedge clk_i);
    chk("training start", 1'b1, t_en);
    chk("detect enable", 1'b1, den);
    chk("force stage one", 1'b0, f1);
    chk("tx interleave", 1'b0, txi);
    $display("test reset_values done");
  endtask
  // default lock count of 120 idles: one short of it must not lock
  task automatic t_lock_default();
    link.send(119, 1'b1, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("locked", 1'b0, lk);
    link.send(1, 1'b1, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("locked", 1'b1, lk);
    $display("test lock_default done");
  endtask
  // default remote threshold of 5 error symbols; a good symbol breaks the run
  task automatic t_remote();
    link.send(4, 1'b0, 1'b1, 1'b0);
    link.send(1, 1'b0, 1'b0, 1'b0);
    link.send(4, 1'b0, 1'b1, 1'b0);
    @(negedge clk_i);
    chk("remote ok", 1'b1, rok);
    link.send(1, 1'b0, 1'b1, 1'b0);
    @(negedge clk_i);
    chk("remote ok", 1'b0, rok);
    link.send(1, 1'b0, 1'b0, 1'b0);
    // the failure flag clears on the good symbol, the output one edge later
    repeat (2) @(negedge clk_i);
    chk("remote ok", 1'b1, rok);
    $display("test remote done");
  endtask
  // default unlock threshold of 10 gap symbols; an idle in the gap restarts the run
  task automatic t_unlock();
    wr(`PSL_IDX_CTRL1, 16'h3078, `PSL_RESP_OKAY);
    link.send(12, 1'b0, 1'b0, 1'b1);
    @(negedge clk_i);
    chk("locked", 1'b1, lk);
    wr(`PSL_IDX_CTRL1, 16'h1078, `PSL_RESP_OKAY);
    link.send(9, 1'b0, 1'b0, 1'b1);
    link.send(1, 1'b1, 1'b0, 1'b1);
    link.send(9, 1'b0, 1'b0, 1'b1);
    @(negedge clk_i);
    chk("locked", 1'b1, lk);
    link.send(1, 1'b0, 1'b0, 1'b1);
    @(negedge clk_i);
    chk("locked", 1'b0, lk);
    chk("remote ok", 1'b0, rok);
    $display("test unlock done");
  endtask
  // link held off, then a short lock count with stalled and broken idle runs
  task automatic t_link_gate();
    wr(`PSL_IDX_CTRL1, 16'h0005, `PSL_RESP_OKAY);
    link.send(8, 1'b1, 1'b0, 1'b0);
    link.show_interleave();
    repeat (2) @(negedge clk_i);
    chk("training start", 1'b0, t_en);
    chk("locked", 1'b0, lk);
    chk("detected", 1'b0, det);
    wr(`PSL_IDX_CTRL1, 16'h9e05, `PSL_RESP_OKAY);
    rd(`PSL_IDX_CTRL1, 16'h1005, `PSL_RESP_OKAY);
    link.slow = 1'b1;
    link.send(4, 1'b1, 1'b0, 1'b0);
    link.send(1, 1'b0, 1'b0, 1'b0);
    link.send(4, 1'b1, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("locked", 1'b0, lk);
    link.send(1, 1'b1, 1'b0, 1'b0);
    @(negedge clk_i);
    chk("locked", 1'b1, lk);
    link.slow = 1'b0;
    $display("test link_gate done");
  endtask
  task automatic t_stage();
    wr(`PSL_IDX_CTRL1, 16'h5005, `PSL_RESP_OKAY);
    @(negedge clk_i);
    chk("force stage one", 1'b1, f1);
    chk("stage one done", 1'b1, s1);
    wr(`PSL_IDX_CTRL1, 16'h1005, `PSL_RESP_OKAY);
    @(negedge clk_i);
    chk("stage one done", 1'b0, s1);
    @(posedge clk_i);
    stage_done <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk("stage one done", 1'b1, s1);
    @(posedge clk_i);
    stage_done <= 1'b0;
    $display("test stage done");
  endtask
  // every transmit interleave mode, detection on and off
  task automatic t_interleave();
    link.show_interleave();
    repeat (2) @(negedge clk_i);
    chk("detected", 1'b1, det);
    chk("tx interleave", 1'b0, txi);
    wr(`PSL_IDX_TXI, 16'h0003, `PSL_RESP_OKAY);
    @(negedge clk_i);
    chk("tx interleave", 1'b1, txi);
    wr(`PSL_IDX_TXI, 16'h0002, `PSL_RESP_OKAY);
    link.show_interleave();
    repeat (2) @(negedge clk_i);
    chk("detect enable", 1'b0, den);
    chk("detected", 1'b0, det);
    chk("tx interleave", 1'b0, txi);
    wr(`PSL_IDX_TXI, 16'hfffc, `PSL_RESP_OKAY);
    rd(`PSL_IDX_TXI, 16'h0004, `PSL_RESP_OKAY);
    @(negedge clk_i);
    chk("tx interleave", 1'b1, txi);
    rd(`PSL_IDX_STATUS, 16'h002d, `PSL_RESP_OKAY);
    $display("test interleave done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // reset for 8 cycles, first request well after the synchroniser lets go
  initial begin
    err_count = 0;
    n_tests = 0;
    rstn_i = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, stage_done} = 6'h00;
    awaddr = 16'h0000;
    araddr = 16'h0000;
    wdata = 32'h00000000;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset_values();
    t_lock_default();
    t_remote();
    t_unlock();
    t_link_gate();
    t_stage();
    t_interleave();
    print_verdict();
  end
  // the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    print_verdict();
  end
endmodule
bind psl_ctrl psl_ctrl_sva chk_u (.clk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
  .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .rx_sym_valid_i, .rx_sym_idle_i, .rx_sym_error_i, .rx_in_gap_i, .rx_interleave_seen_i, .training_start_en_o,
  .force_training_stage_one_complete_o, .stage_one_done_o, .scrambler_locked_o, .remote_rcvr_ok_o,
  .interleave_detect_en_o, .interleave_detected_o);
`default_nettype wire
